// ---- hdl/eif_defines.svh ----
`ifndef EIF_DEFINES_SVH
`define EIF_DEFINES_SVH

// register byte offsets (0x37 is not a multiple of four: index times four)
`define EIF_IDX_CONTROL 8'h37
`define EIF_ADDR_CONTROL 12'h0DC
`define EIF_ADDR_STATUS 12'h100
`define EIF_ADDR_MASK 12'h104
`define EIF_ADDR_MODE 12'h108

// control register fields
`define EIF_BIT_IRQ1_EDGE 1
`define EIF_BIT_IRQ2_EDGE 2
`define EIF_BIT_IRQ4_EDGE 4
`define EIF_BIT_IRQ0_PIN_EN 6
`define EIF_BIT_IRQ1_NOISE 7
`define EIF_CONTROL_RESET 8'h00
`define EIF_CONTROL_WMASK 8'hD6

// mode register fields
`define EIF_BIT_SLOW 0
`define EIF_BIT_STOP_HIZ 1

// filter times in cycles of fc
`define EIF_IRQ1_SHORT_FC 15
`define EIF_IRQ1_LONG_FC 63
`define EIF_IRQ24_FC 7

`endif

// ---- hdl/eif_pkg.sv ----
package eif_pkg;

  typedef struct packed {
    logic irq1_noise_time_sel;
    logic irq0_pin_enable;
    logic irq4_edge_sel;
    logic irq2_edge_sel;
    logic irq1_edge_sel;
  } eif_ctrl_t;

  typedef struct packed {
    logic slow;
    logic stop_hiz;
  } eif_mode_t;

  typedef enum logic [1:0] {
    EIF_AX_IDLE = 2'b00,
    EIF_AX_RESP = 2'b01
  } eif_wr_state_t;

endpackage

// ---- hdl/eif_ext_irq.sv ----
`timescale 1ns/1ps
`include "eif_defines.svh"

module eif_ext_irq
  import eif_pkg::*;
#(
  parameter int FILT_W = 6
)
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [5:0] ext_irq_pins,
  input wire logic [5:0] irq_accept,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [5:0] irq_latch,
  output logic port1_bit0_in,
  output logic timer_one_input,
  output logic irq
);

  eif_ctrl_t ctrl_q;
  eif_mode_t mode_q;
  logic [5:0] mask_q;
  logic [5:0] irq_latch_q;
  logic [5:0] sync1_q;
  logic [5:0] sync2_q;
  logic [5:0] filt_q;
  logic [5:0] filt_prev_q;
  logic [FILT_W-1:0] cnt_q [5:0];
  logic [2:0] esel_prev_q;
  logic [5:0] pin_in;
  logic [5:0] event_set;
  logic [5:0] edge_pol;
  logic esel_changed;

  logic aw_hold_q;
  logic w_hold_q;
  logic [11:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  eif_wr_state_t wr_st_q;
  logic wr_fire;
  logic [5:0] w1c;

  function automatic logic [FILT_W-1:0] filt_limit(input int idx,
                                                   input eif_ctrl_t c);
    if (idx == 1)
      filt_limit = c.irq1_noise_time_sel ?
        FILT_W'(`EIF_IRQ1_SHORT_FC) : FILT_W'(`EIF_IRQ1_LONG_FC);
    else
      filt_limit = FILT_W'(`EIF_IRQ24_FC);
  endfunction

  // stop high impedance forces all inputs but input five low
  always_comb
  begin
    pin_in = ext_irq_pins;
    if (mode_q.stop_hiz)
      pin_in[4:0] = 5'h00;
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      sync1_q <= 6'h3F;
      sync2_q <= 6'h3F;
    end
    else
    begin
      sync1_q <= pin_in;
      sync2_q <= sync1_q;
    end
  end

  // filter on inputs one, two and four outside slow mode: output follows the input only after it stayed stable past limit
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      filt_q <= 6'h3F;
      for (int i = 0; i < 6; i++)
        cnt_q[i] <= '0;
    end
    else
    begin
      for (int i = 0; i < 6; i++)
      begin
        if (i == 1 || i == 2 || i == 4)
        begin
          if (sync2_q[i] == filt_q[i] || mode_q.slow)
          begin
            cnt_q[i] <= '0;
            filt_q[i] <= sync2_q[i];
          end
          else if (cnt_q[i] >= filt_limit(i, ctrl_q))
          begin
            cnt_q[i] <= '0;
            filt_q[i] <= sync2_q[i];
          end
          else
            cnt_q[i] <= cnt_q[i] + FILT_W'(1);
        end
        else
        begin
          cnt_q[i] <= '0;
          filt_q[i] <= sync2_q[i];
        end
      end
    end
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      filt_prev_q <= 6'h3F;
      esel_prev_q <= 3'h0;
    end
    else
    begin
      filt_prev_q <= filt_q;
      esel_prev_q <= {ctrl_q.irq4_edge_sel, ctrl_q.irq2_edge_sel,
                      ctrl_q.irq1_edge_sel};
    end
  end

  assign esel_changed = esel_prev_q != {ctrl_q.irq4_edge_sel,
                        ctrl_q.irq2_edge_sel, ctrl_q.irq1_edge_sel};

  // edge select 1 means rising; zero, three and five fixed falling
  always_comb
  begin
    edge_pol = 6'h00;
    edge_pol[1] = ctrl_q.irq1_edge_sel;
    edge_pol[2] = ctrl_q.irq2_edge_sel;
    edge_pol[4] = ctrl_q.irq4_edge_sel;
    for (int i = 0; i < 6; i++)
      event_set[i] = edge_pol[i] ? (filt_q[i] & ~filt_prev_q[i])
                                 : (~filt_q[i] & filt_prev_q[i]);
    event_set[0] = event_set[0] & ctrl_q.irq0_pin_enable;
    if (esel_changed)
      event_set[4:1] = 4'h0;
  end

  assign timer_one_input = filt_q[2];
  assign port1_bit0_in = sync2_q[0];

  // axi write path: address and data taken in either order
  assign s_axi_awready = !aw_hold_q && wr_st_q == EIF_AX_IDLE;
  assign s_axi_wready = !w_hold_q && wr_st_q == EIF_AX_IDLE;
  assign wr_fire = wr_st_q == EIF_AX_IDLE &&
    (aw_hold_q || s_axi_awvalid) && (w_hold_q || s_axi_wvalid);

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      aw_hold_q <= 1'b0;
      w_hold_q <= 1'b0;
      awaddr_q <= 12'h000;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
      wr_st_q <= EIF_AX_IDLE;
      s_axi_bvalid <= 1'b0;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_hold_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_hold_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      unique case (wr_st_q)
        EIF_AX_IDLE:
          if (wr_fire)
          begin
            aw_hold_q <= 1'b0;
            w_hold_q <= 1'b0;
            s_axi_bvalid <= 1'b1;
            wr_st_q <= EIF_AX_RESP;
          end
        EIF_AX_RESP:
          if (s_axi_bready)
          begin
            s_axi_bvalid <= 1'b0;
            wr_st_q <= EIF_AX_IDLE;
          end
        default:
          wr_st_q <= EIF_AX_IDLE;
      endcase
    end
  end

  assign s_axi_bresp = 2'b00;

  // current write payload, whether held or live
  logic [11:0] wa;
  logic [31:0] wd;
  logic wb0;
  assign wa = aw_hold_q ? awaddr_q : s_axi_awaddr;
  assign wd = w_hold_q ? wdata_q : s_axi_wdata;
  assign wb0 = w_hold_q ? wstrb_q[0] : s_axi_wstrb[0];
  assign w1c = (wr_fire && wb0 && {wa[11:2], 2'b00} == `EIF_ADDR_STATUS) ?
               wd[5:0] : 6'h00;

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      ctrl_q <= eif_ctrl_t'(5'h00);
      mode_q <= eif_mode_t'(2'h0);
      mask_q <= 6'h00;
    end
    else if (wr_fire && wb0)
    begin
      unique case ({wa[11:2], 2'b00})
        `EIF_ADDR_CONTROL:
          ctrl_q <= '{irq1_noise_time_sel: wd[`EIF_BIT_IRQ1_NOISE],
                      irq0_pin_enable: wd[`EIF_BIT_IRQ0_PIN_EN],
                      irq4_edge_sel: wd[`EIF_BIT_IRQ4_EDGE],
                      irq2_edge_sel: wd[`EIF_BIT_IRQ2_EDGE],
                      irq1_edge_sel: wd[`EIF_BIT_IRQ1_EDGE]};
        `EIF_ADDR_MASK:
          mask_q <= wd[5:0];
        `EIF_ADDR_MODE:
          mode_q <= '{slow: wd[`EIF_BIT_SLOW],
                      stop_hiz: wd[`EIF_BIT_STOP_HIZ]};
        default:
          ;
      endcase
    end
  end

  // set beats clear so no edge is lost
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      irq_latch_q <= 6'h00;
    else
      irq_latch_q <= event_set
                     | (irq_latch_q & ~w1c & ~irq_accept);
  end

  assign irq_latch = irq_latch_q;
  assign irq = |(irq_latch_q & mask_q);

  // read path, one cycle after address taken
  logic [7:0] ctrl_byte;
  assign ctrl_byte = {ctrl_q.irq1_noise_time_sel, ctrl_q.irq0_pin_enable,
                      1'b0, ctrl_q.irq4_edge_sel, 1'b0,
                      ctrl_q.irq2_edge_sel, ctrl_q.irq1_edge_sel, 1'b0};
  assign s_axi_arready = !s_axi_rvalid;
  assign s_axi_rresp = 2'b00;

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_rvalid <= 1'b1;
      unique case ({s_axi_araddr[11:2], 2'b00})
        `EIF_ADDR_CONTROL: s_axi_rdata <= {24'h000000, ctrl_byte};
        `EIF_ADDR_STATUS: s_axi_rdata <= {26'h0, irq_latch_q};
        `EIF_ADDR_MASK: s_axi_rdata <= {26'h0, mask_q};
        // read back in the same bit order as the write
        `EIF_ADDR_MODE:
          s_axi_rdata <= {30'h0, mode_q.stop_hiz, mode_q.slow};
        default: s_axi_rdata <= 32'h0000_0000;
      endcase
    end
    else if (s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end

endmodule

// ---- verif/eif_src_model.sv ----
`timescale 1ns/1ps
module eif_src_model (
  input wire logic clk_sys,
  output logic [5:0] pins
);
  // idle sources sit high, so an unused pin never makes an edge
  initial pins = 6'h3F;
  task automatic drive(input int n, input logic lvl, input int w);
    int k;
    k = ((n == 0 || n == 5) && w < 5) ? 5 : w;
    @(posedge clk_sys);
    pins[n] <= lvl;
    repeat (k) @(posedge clk_sys);
  endtask
endmodule

// ---- verif/eif_monitor.sv ----
`timescale 1ns/1ps
module eif_monitor (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [5:0] ext_irq_pins,
  input wire logic [5:0] irq_accept,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [5:0] irq_latch,
  input wire logic port1_bit0_in,
  input wire logic irq
);
  default clocking @(posedge clk_sys);
  endclocking
  default disable iff (rst);
  // a software clear lands at the same edge as the write response rises
  chk_latch_hold: assert property (
    |($past(irq_latch) & ~irq_latch & ~$past(irq_accept))
    |-> $rose(s_axi_bvalid)) else $error("latch lost");
  chk_irq_cause: assert property (
    irq |-> |irq_latch) else $error("irq without latch");
  chk_port_low: assert property (
    !ext_irq_pins[0] [*4] |-> !port1_bit0_in) else $error("port stale");
  chk_five_fall: assert property (
    $fell(ext_irq_pins[5]) |-> ##[1:8] irq_latch[5])
    else $error("input five missed");
  chk_b_hold: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid) else $error("b drop");
  chk_r_hold: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("r drop");
  chk_r_answer: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("r late");
  chk_b_okay: assert property (
    s_axi_bvalid |-> s_axi_bresp == 2'h0 && !s_axi_awready && !s_axi_wready)
    else $error("b bad");
  cover property ($rose(irq));
  cover property ($rose(irq_latch[1]));
  cover property (s_axi_bvalid && s_axi_bready);
endmodule
bind eif_ext_irq eif_monitor mon (.*);

// ---- verif/tb_external_interrupt_edge_filter.sv ----
`timescale 1ns/1ps
`include "eif_defines.svh"
module tb_external_interrupt_edge_filter
  import eif_pkg::*;
;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic [5:0] ext_irq_pins, irq_latch;
  logic [5:0] irq_accept = 6'h00;
  logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic s_axi_arready, s_axi_rvalid, port1_bit0_in, timer_one_input, irq;
  logic [7:0] v;
  int miscompares = 0;
  int tests_run = 0;
  always #25 clk_sys = ~clk_sys;
  eif_src_model src (.clk_sys(clk_sys), .pins(ext_irq_pins));
  eif_ext_irq dut (.*);
  task automatic close_out();
    $display("miscompares %0d tests_run %0d", miscompares, tests_run);
    if (miscompares == 0 && tests_run > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [7:0] e,
                     input logic [7:0] g);
    tests_run++;
    if (g !== e)
    begin
      miscompares++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic bound(input int t);
    if (t >= 40)
    begin
      miscompares++;
      close_out();
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    int t;
    t = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(posedge clk_sys);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      t++;
    end
    while (!s_axi_bvalid && t < 40);
    s_axi_bready <= 1'b0;
    @(posedge clk_sys);
    bound(t);
  endtask
  task automatic rd(input logic [11:0] a, output logic [7:0] d);
    int t;
    t = 0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      @(posedge clk_sys);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      t++;
    end
    while (!s_axi_rvalid && t < 40);
    d = s_axi_rdata[7:0];
    chk("rresp", 8'h00, {6'h00, s_axi_rresp});
    s_axi_rready <= 1'b0;
    @(posedge clk_sys);
    bound(t);
  endtask
  // settle time covers the longest filter before latches are cleared
  task automatic setc(input logic [7:0] d);
    wr(`EIF_ADDR_CONTROL, d);
    repeat (200) @(posedge clk_sys);
  endtask
  task automatic pin_case(input int n, input int w, input logic [5:0] e);
    wr(`EIF_ADDR_STATUS, 8'h3F);
    src.drive(n, 1'b0, w);
    src.drive(n, 1'b1, 210);
    chk("latch", {2'h0, e}, {2'h0, irq_latch});
  endtask
  task automatic sc_reset();
    rd(`EIF_ADDR_CONTROL, v);
    chk("control", 8'h00, v);
    chk("port", 8'h01, {7'h0, port1_bit0_in});
    pin_case(0, 8, 6'h00);
    rd(12'h0FC, v);
    chk("unmapped", 8'h00, v);
    // a write with the low byte strobe off must leave the register alone
    s_axi_wstrb <= 4'h0;
    wr(`EIF_ADDR_CONTROL, 8'hFF);
    s_axi_wstrb <= 4'hF;
    rd(`EIF_ADDR_CONTROL, v);
    chk("no strobe", 8'h00, v);
    setc(8'hFF);
    rd(`EIF_ADDR_CONTROL, v);
    chk("control bits", 8'hD6, v);
  endtask
  task automatic sc_filter();
    setc(8'hC0);
    pin_case(0, 8, 6'h01);
    pin_case(5, 8, 6'h20);
    wr(`EIF_ADDR_STATUS, 8'h3F);
    src.drive(2, 1'b0, 5);
    chk("timer glitch", 8'h01, {7'h0, timer_one_input});
    src.drive(2, 1'b1, 210);
    chk("short pulse", 8'h00, {2'h0, irq_latch});
    pin_case(1, 12, 6'h00);
    pin_case(1, 48, 6'h02);
    wr(`EIF_ADDR_STATUS, 8'h3F);
    src.drive(4, 1'b0, 26);
    chk("latency", 8'h10, {2'h0, irq_latch});
    src.drive(4, 1'b1, 10);
    setc(8'h40);
    pin_case(1, 60, 6'h00);
    pin_case(1, 192, 6'h02);
  endtask
  task automatic sc_edge();
    setc(8'hD6);
    wr(`EIF_ADDR_STATUS, 8'h3F);
    src.drive(2, 1'b0, 40);
    chk("fall", 8'h00, {2'h0, irq_latch});
    chk("timer", 8'h00, {7'h0, timer_one_input});
    src.drive(2, 1'b1, 40);
    chk("rise", 8'h04, {2'h0, irq_latch});
    wr(`EIF_ADDR_MASK, 8'h3F);
    chk("irq on", 8'h01, {7'h0, irq});
    wr(`EIF_ADDR_MASK, 8'h00);
    chk("irq off", 8'h00, {7'h0, irq});
    rd(`EIF_ADDR_STATUS, v);
    chk("held", 8'h04, v);
    irq_accept <= 6'h04;
    @(posedge clk_sys);
    irq_accept <= 6'h00;
    @(posedge clk_sys);
    rd(`EIF_ADDR_STATUS, v);
    chk("accepted", 8'h00, v);
  endtask
  task automatic sc_mode();
    setc(8'h40);
    wr(`EIF_ADDR_MODE, 8'h01);
    rd(`EIF_ADDR_MODE, v);
    chk("mode", 8'h01, v);
    pin_case(2, 3, 6'h04);
    wr(`EIF_ADDR_MODE, 8'h00);
    wr(`EIF_ADDR_STATUS, 8'h3F);
    wr(`EIF_ADDR_MODE, 8'h02);
    repeat (200) @(posedge clk_sys);
    chk("stop", 8'h17, {2'h0, irq_latch & 6'h37});
    wr(`EIF_ADDR_MODE, 8'h00);
  endtask
  initial
  begin
    repeat (12) @(posedge clk_sys);
    rst <= 1'b0;
    sc_reset();
    sc_filter();
    sc_edge();
    sc_mode();
    close_out();
  end
endmodule
